// ### tb_top.sv
// self-checking bench for the vector board i/o front end
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import vgio_pkg::*;
;
   logic        clk;
   logic        sys_rst, bus_init_n, test_reset_n, decode_n, hold_req;
   vgio_bus_s   bus;
   vgio_ctl_s   ctl;
   logic        ack_n, rdata_oe, hw_n, clr_a_n, clr_b_n, clr_c_n;
   logic        done_n, zero_n, zdly_n, xdir, ydir, xstep_n, ystep_n;
   logic [15:0] rdata;
   logic [2:0]  clr_seen = 3'b000;
   logic        hw_seen = 1'b0;
   logic        clk_en = 1'b1;
   logic        seen_arm = 1'b0;
   int          n_fail = 0, samples_checked = 0, cycles = 0, n;

   vgio_top i_dut (
      .CLK(clk), .CLK_EN(clk_en), .SYS_RST(sys_rst), .BUS_INIT_N(bus_init_n),
      .TEST_RESET_N(test_reset_n), .BUS(bus), .COMMON_ADDR_DECODE_N(decode_n),
      .HOLD_REQ(hold_req), .SYSTEM_WRITE_ACK_N(ack_n), .RDATA(rdata), .RDATA_OE(rdata_oe),
      .CTL(ctl), .HW_ONLY_RESET_SYNC_N(hw_n), .BLOCK_CLEAR_A_N(clr_a_n),
      .BLOCK_CLEAR_B_N(clr_b_n), .BLOCK_CLEAR_C_N(clr_c_n), .SHORT_LOOP_DONE_N(done_n),
      .LONG_LOOP_ZERO_N(zero_n), .LONG_LOOP_ZERO_DELAYED_N(zdly_n),
      .X_COUNT_DIRECTION(xdir), .Y_COUNT_DIRECTION(ydir),
      .X_STEP_EN_N(xstep_n), .Y_STEP_EN_N(ystep_n)
   );

   vgio_host_model i_host (
      .clk(clk), .bus(bus), .ack_n(ack_n), .rdata(rdata), .rdata_oe(rdata_oe)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // once armed, remembers any clear or hardware reset pulse seen at an edge
   always @(posedge clk) begin
      if (seen_arm) begin
         clr_seen <= clr_seen | ~{clr_a_n, clr_b_n, clr_c_n};
         hw_seen <= hw_seen | ~hw_n;
      end
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // board base has address bits 5, 6, 7 and 10 set
   function automatic logic [15:0] adr(input logic [3:0] i);
      return 16'h04e0 | {11'h000, i, 1'b0};
   endfunction

   function automatic logic [15:0] drop(input int k);
      int b[4] = '{SEL_BIT_A, SEL_BIT_B, SEL_BIT_C, SEL_BIT_D};
      return (k < 4) ? ~(16'h0001 << b[k]) : 16'hffff;
   endfunction

   task automatic wa(input logic [15:0] a, input logic [15:0] d);
      int m;
      i_host.write_cycle(a, d, m);
      chk("ack_cycles", 16'h0004, 16'(m));
      #1;
      chk("ack_release", 16'h0001, {15'h0000, ack_n});
   endtask

   task automatic wr(input logic [3:0] i, input logic [15:0] d);
      wa(adr(i), d);
   endtask

   task automatic rd(input logic [3:0] i, input logic [15:0] e, input logic eoe);
      logic [15:0] q;
      logic        oe;
      i_host.read_cycle(adr(i), q, oe);
      chk("read_oe", {15'h0000, eoe}, {15'h0000, oe});
      chk("read_data", e, q);
   endtask

   // b: 3 reload, 2 short count, 1 long count, 0 slope step
   task automatic pulse_ctl(input int b, input int c);
      @(posedge clk);
      ctl[b] <= 1'b0;
      repeat (c) @(posedge clk);
      ctl[b] <= 1'b1;
   endtask

   task automatic stp(input logic [1:0] e);
      chk("step_en", {14'h0000, e}, {14'h0000, xstep_n, ystep_n});
   endtask

   initial begin
      sys_rst = 1'b1;
      bus_init_n = 1'b1;
      test_reset_n = 1'b1;
      decode_n = 1'b0;
      hold_req = 1'b0;
      ctl = '1;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk("clears", 16'h000f, {12'h000, hw_n, clr_a_n, clr_b_n, clr_c_n});
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         bus_init_n <= (k != 0);
         test_reset_n <= (k == 0);
         repeat (2) @(posedge clk);
         chk("hw_reset", 16'h0000, {12'h000, hw_n, clr_a_n, clr_b_n, clr_c_n});
         bus_init_n <= 1'b1;
         test_reset_n <= 1'b1;
         repeat (2) @(posedge clk);
      end
      hold_req <= 1'b1;
      fork
         i_host.write_cycle(adr(W_SHORT), 16'h0007, n);
         begin
            repeat (6) @(posedge clk);
            chk("ack_held", 16'h0001, {15'h0000, ack_n});
            hold_req <= 1'b0;
         end
      join
      chk("hold_cycles", 16'h0009, 16'(n));
      rd(R_SHORT, 16'h0007, 1'b1);
      wr(W_SHORT, 16'h0002);
      pulse_ctl(2, 3);
      rd(R_SHORT, 16'h0000, 1'b1);
      chk("short_done", 16'h0000, {15'h0000, done_n});
      pulse_ctl(3, 1);
      rd(R_SHORT, 16'h0002, 1'b1);
      chk("short_done", 16'h0001, {15'h0000, done_n});
      wr(W_SHORT, 16'h12b5);
      rd(R_SHORT, 16'h00b5, 1'b1);
      // clock enable low freezes the counter
      clk_en <= 1'b0;
      pulse_ctl(2, 2);
      clk_en <= 1'b1;
      rd(R_SHORT, 16'h00b5, 1'b1);
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         decode_n <= (k == 4);
         wa((k == 5) ? adr(4'h8) : adr(W_SHORT) & drop(k), 16'h0033);
      end
      decode_n <= 1'b0;
      rd(R_SHORT, 16'h00b5, 1'b1);
      rd(4'h2, 16'h0000, 1'b0);
      wr(W_LONG, 16'h0003);
      pulse_ctl(1, 3);
      #1 chk("long_zero", 16'h0001, {14'h0000, zero_n, zdly_n});
      repeat (2) @(posedge clk);
      #1 chk("long_hold", 16'h0001, {14'h0000, zero_n, zdly_n});
      pulse_ctl(1, 1);
      #1 chk("long_dly", 16'h0000, {14'h0000, zero_n, zdly_n});
      wr(W_LONG, 16'hffff);
      chk("long_load", 16'h0001, {15'h0000, zdly_n});
      rd(R_LONG, 16'h0fff, 1'b1);
      wr(W_INC_A, 16'h0100);
      wr(W_ACCUM, 16'h7000);
      rd(R_ACCUM, 16'h0000, 1'b1);
      wr(W_AXIS, 16'h0005);
      chk("axis_dir", 16'h0002, {14'h0000, xdir, ydir});
      wr(W_INC_B, 16'h2000);
      rd(R_ACCUM, 16'h7000, 1'b1);
      stp(2'b11);
      @(posedge clk);
      ctl[0] <= 1'b0;
      #1 stp(2'b00);
      @(posedge clk);
      #1 stp(2'b10);
      @(posedge clk);
      ctl[0] <= 1'b1;
      rd(R_ACCUM, 16'h9100, 1'b1);
      wr(W_AXIS, 16'h0002);
      chk("axis_dir", 16'h0001, {14'h0000, xdir, ydir});
      rd(R_ACCUM, 16'h9200, 1'b1);
      @(posedge clk);
      ctl[0] <= 1'b0;
      #1 stp(2'b01);
      @(posedge clk);
      ctl[0] <= 1'b1;
      seen_arm <= 1'b1;
      wr(W_SWRST, 16'h0000);
      chk("sw_clear", 16'h0007, {12'h000, hw_seen, clr_seen});
      rd(R_SHORT, {8'h00, SHORT_RST}, 1'b1);
      tally_and_finish();
   end

endmodule // tb_top
`default_nettype wire

// ### vgio_host_model.sv
// host processor model that drives the display i/o bus
`timescale 1ns/1ps
`default_nettype none

module vgio_host_model
   import vgio_pkg::*;
(
   // clock
   input  wire logic        clk,
   // display bus
   output var  vgio_bus_s   bus,
   input  wire logic        ack_n,
   input  wire logic [15:0] rdata,
   input  wire logic        rdata_oe
);

   initial begin
      bus = '{addr: 16'h0000, wdata: 16'h0000, io_read_ctl_n: 1'b1, io_write_ctl_n: 1'b1};
   end

   // n counts edges from the request to the release edge, one past the edge that sees the acknowledge
   task automatic write_cycle(input logic [15:0] a, input logic [15:0] d, output int n);
      n = 0;
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.io_write_ctl_n <= 1'b0;
      // hold until acknowledge; ack is looked at once settled
      do begin
         @(posedge clk);
         n++;
         #1;
      end while (ack_n !== 1'b0 && n < 40);
      // release only after the edge that samples the acknowledge
      @(posedge clk);
      n++;
      bus.io_write_ctl_n <= 1'b1;
      // released data lines no longer show the written word
      bus.wdata <= ~d;
   endtask

   task automatic read_cycle(input logic [15:0] a, output logic [15:0] q, output logic oe);
      @(posedge clk);
      bus.addr <= a;
      bus.io_read_ctl_n <= 1'b0;
      @(posedge clk);
      oe = rdata_oe;
      @(posedge clk);
      q = rdata;
      bus.io_read_ctl_n <= 1'b1;
      bus.addr <= ~a;
   endtask

endmodule // vgio_host_model
`default_nettype wire

// ### vgio_pkg.sv
// package: constants and types for the vector board i/o front end
package vgio_pkg;

   // upper board address bits that must all be true (5,6,7 and 10)
   localparam int          SEL_BIT_A   = 5;
   localparam int          SEL_BIT_B   = 6;
   localparam int          SEL_BIT_C   = 7;
   localparam int          SEL_BIT_D   = 10;
   localparam int          STRB_LO     = 1;
   localparam int          STRB_HI     = 3;
   localparam int          GRP_BIT     = 4;
   localparam int          ADDR_W      = 16;
   localparam int          DATA_W      = 16;
   localparam int          NSTRB       = 16;

   // write strobe indices
   localparam logic [3:0]  W_SHORT     = 4'h0;
   localparam logic [3:0]  W_LONG      = 4'h1;
   localparam logic [3:0]  W_AXIS      = 4'h2;
   localparam logic [3:0]  W_INC_A     = 4'h3;
   localparam logic [3:0]  W_ACCUM     = 4'h4;
   localparam logic [3:0]  W_INC_B     = 4'h5;
   localparam logic [3:0]  W_SWRST     = 4'h6;
   // read strobe indices
   localparam logic [3:0]  R_SHORT     = 4'h0;
   localparam logic [3:0]  R_LONG      = 4'h1;
   localparam logic [3:0]  R_ACCUM     = 4'h4;

   localparam int          SHORT_W     = 8;
   localparam int          LONG_W      = 12;
   localparam int          ACC_W       = 16;
   localparam int          AXIS_X_BIT  = 0;
   localparam int          AXIS_Y_BIT  = 1;
   localparam int          AXIS_SW_BIT = 2;

   localparam logic [7:0]  SHORT_RST   = 8'h00;
   localparam logic [11:0] LONG_RST    = 12'h000;
   localparam logic [15:0] ACC_RST     = 16'h0000;
   localparam logic [2:0]  AXIS_RST    = 3'h0;
   localparam logic [15:0] DATA_ZERO   = 16'h0000;

   typedef enum logic [1:0] {
      VGIO_WS_IDLE = 2'b00,
      VGIO_WS_ARM  = 2'b01,
      VGIO_WS_PULS = 2'b10,
      VGIO_WS_ACK  = 2'b11
   } vgio_wsync_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              io_read_ctl_n;
      logic              io_write_ctl_n;
   } vgio_bus_s;

   typedef struct packed {
      logic short_loop_reload_n;
      logic short_loop_count_en_n;
      logic long_loop_count_en_n;
      logic slope_step_en_n;
   } vgio_ctl_s;

endpackage : vgio_pkg

// ### vgio_top.sv
// module: vector board i/o decode, write sync, loop counters and slope generator
//
// Behaviour
// - board select needs address bits and common decode
// - OR bus init and test reset, then register
// - software reset strobe adds to block clears
// - hardware-only reset goes out separately
// - addr 1-3 pick strobe, bit 4 picks group
// - strobes gated by select and read or sync write
// - write pulse one clock, acknowledge as it ends
// - ack drops on release, idle next edge
// - hold request blocks write sync start
// - sync and ack run on every write
// - short counter counts down, holds at zero
// - short counter done when count zero
// - short counter readback on low eight bits
// - short write loads counter and latch
// - reload restores counter from latch only
// - long counter rw, counts down, stops, flags zero
// - delayed zero cleared on load, held when idle
// - axis register: directions and axis swap
// - accumulator adds increment chosen by sign
// - accum port write clears, stages into b
// - axis write clocks accumulator once
// - sign and swap choose step enables
// - accumulator readback on read strobe
`timescale 1ns/1ps
`default_nettype none

module vgio_top
   import vgio_pkg::*;
(
   // clock, enable, resets
   input  wire logic                CLK,
   input  wire logic                CLK_EN,
   input  wire logic                SYS_RST,
   input  wire logic                BUS_INIT_N,
   input  wire logic                TEST_RESET_N,
   // display bus
   input  wire vgio_bus_s           BUS,
   input  wire logic                COMMON_ADDR_DECODE_N,
   input  wire logic                HOLD_REQ,
   output logic                     SYSTEM_WRITE_ACK_N,
   output logic [DATA_W-1:0]        RDATA,
   output logic                     RDATA_OE,
   // state controller side
   input  wire vgio_ctl_s           CTL,
   output logic                     HW_ONLY_RESET_SYNC_N,
   output logic                     BLOCK_CLEAR_A_N,
   output logic                     BLOCK_CLEAR_B_N,
   output logic                     BLOCK_CLEAR_C_N,
   output logic                     SHORT_LOOP_DONE_N,
   output logic                     LONG_LOOP_ZERO_N,
   output logic                     LONG_LOOP_ZERO_DELAYED_N,
   // axis control
   output logic                     X_COUNT_DIRECTION,
   output logic                     Y_COUNT_DIRECTION,
   output logic                     X_STEP_EN_N,
   output logic                     Y_STEP_EN_N
);

   vgio_wsync_e         ws_state;
   vgio_wsync_e         next_ws_state;
   logic                rst_sync;
   logic [SHORT_W-1:0]  short_cnt;
   logic [SHORT_W-1:0]  short_latch;
   logic [LONG_W-1:0]   long_cnt;
   logic                long_zero_dly;
   logic [2:0]          axis_ctl;
   logic [ACC_W-1:0]    inc_a;
   logic [ACC_W-1:0]    inc_b;
   logic [ACC_W-1:0]    accum;

   wire board_sel = BUS.addr[SEL_BIT_A] & BUS.addr[SEL_BIT_B] & BUS.addr[SEL_BIT_C]
                    & BUS.addr[SEL_BIT_D] & ~COMMON_ADDR_DECODE_N;

   wire sync_wr = (ws_state == VGIO_WS_PULS);

   wire [3:0] strb_idx = {BUS.addr[GRP_BIT], BUS.addr[STRB_HI:STRB_LO]};
   wire [NSTRB-1:0] wr_strb;
   wire [NSTRB-1:0] rd_strb;

   genvar gi;
   generate
      for (gi = 0; gi < NSTRB; gi++) begin : g_strb
         assign wr_strb[gi] = board_sel & sync_wr & (strb_idx == 4'(gi));
         assign rd_strb[gi] = board_sel & ~BUS.io_read_ctl_n & (strb_idx == 4'(gi));
      end
   endgenerate

   wire wr_short = wr_strb[W_SHORT];
   wire wr_long  = wr_strb[W_LONG];
   wire wr_axis  = wr_strb[W_AXIS];
   wire wr_inc_a = wr_strb[W_INC_A];
   wire wr_accum = wr_strb[W_ACCUM];
   wire wr_inc_b = wr_strb[W_INC_B];
   wire wr_swrst = wr_strb[W_SWRST];

   // block clears combine software and hardware reset
   wire clr = rst_sync | wr_swrst;
   assign BLOCK_CLEAR_A_N = ~clr;
   assign BLOCK_CLEAR_B_N = ~clr;
   assign BLOCK_CLEAR_C_N = ~clr;
   assign HW_ONLY_RESET_SYNC_N = ~rst_sync;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rst_sync <= 1'b1;
      end else if (CLK_EN) begin
         rst_sync <= ~BUS_INIT_N | ~TEST_RESET_N;
      end
   end

   wire wr_start = ~BUS.io_write_ctl_n & ~HOLD_REQ;

   // runs on every bus write, not only selected ones
   always_comb begin
      next_ws_state = ws_state;
      unique case (ws_state)
         VGIO_WS_IDLE: if (wr_start) next_ws_state = VGIO_WS_ARM;
         VGIO_WS_ARM:  next_ws_state = VGIO_WS_PULS;
         VGIO_WS_PULS: next_ws_state = VGIO_WS_ACK;
         // back to idle once write released
         VGIO_WS_ACK:  if (BUS.io_write_ctl_n) next_ws_state = VGIO_WS_IDLE;
      endcase
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ws_state <= VGIO_WS_IDLE;
      end else if (CLK_EN) begin
         ws_state <= next_ws_state;
      end
   end

   // ack drops as soon as write released
   assign SYSTEM_WRITE_ACK_N = ~((ws_state == VGIO_WS_ACK) & ~BUS.io_write_ctl_n);

   wire short_en  = ~CTL.short_loop_count_en_n;
   wire short_pop = ~CTL.short_loop_reload_n;
   wire long_en   = ~CTL.long_loop_count_en_n;
   wire dda_en    = ~CTL.slope_step_en_n;

   wire short_zero = (short_cnt == SHORT_RST);
   assign SHORT_LOOP_DONE_N = ~short_zero;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         short_cnt   <= SHORT_RST;
         short_latch <= SHORT_RST;
      end else if (CLK_EN && clr) begin
         // block clear empties counter and latch
         short_cnt   <= SHORT_RST;
         short_latch <= SHORT_RST;
      end else if (CLK_EN) begin
         if (wr_short) begin
            short_cnt   <= BUS.wdata[SHORT_W-1:0];
            short_latch <= BUS.wdata[SHORT_W-1:0];
         end else if (short_pop) begin
            short_cnt <= short_latch;
         end else if (short_en && !short_zero) begin
            short_cnt <= short_cnt - 8'h01;
         end
      end
   end

   wire long_zero = (long_cnt == LONG_RST);
   assign LONG_LOOP_ZERO_N         = ~long_zero;
   assign LONG_LOOP_ZERO_DELAYED_N = ~long_zero_dly;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         long_cnt      <= LONG_RST;
         long_zero_dly <= 1'b0;
      end else if (CLK_EN && clr) begin
         // block clear empties counter and flag
         long_cnt      <= LONG_RST;
         long_zero_dly <= 1'b0;
      end else if (CLK_EN) begin
         if (wr_long) begin
            long_cnt      <= BUS.wdata[LONG_W-1:0];
            long_zero_dly <= 1'b0;
         end else if (long_en) begin
            long_zero_dly <= long_zero;
            if (!long_zero) begin
               long_cnt <= long_cnt - 12'h001;
            end
         end
      end
   end

   assign X_COUNT_DIRECTION = axis_ctl[AXIS_X_BIT];
   assign Y_COUNT_DIRECTION = axis_ctl[AXIS_Y_BIT];
   wire   axis_swap         = axis_ctl[AXIS_SW_BIT];

   wire              acc_sign = accum[ACC_W-1];
   wire [ACC_W-1:0]  acc_add  = acc_sign ? inc_a : inc_b;
   wire [ACC_W-1:0]  acc_sum  = accum + acc_add;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         axis_ctl <= AXIS_RST;
         inc_a    <= ACC_RST;
         inc_b    <= ACC_RST;
         accum    <= ACC_RST;
      end else if (CLK_EN && clr) begin
         // block clear empties axis, increments and accumulator
         axis_ctl <= AXIS_RST;
         inc_a    <= ACC_RST;
         inc_b    <= ACC_RST;
         accum    <= ACC_RST;
      end else if (CLK_EN) begin
         // increment a write has no side effect
         if (wr_inc_a) begin
            inc_a <= BUS.wdata;
         end
         if (wr_inc_b || wr_accum) begin
            inc_b <= BUS.wdata;
         end
         if (wr_axis) begin
            axis_ctl <= BUS.wdata[2:0];
         end
         if (wr_accum) begin
            accum <= ACC_RST;
         end else if (wr_axis || dda_en) begin
            // axis write steps once; step only when enabled
            accum <= acc_sum;
         end
      end
   end

   // major always, minor when sign shows a minor move
   wire minor_step = dda_en & ~acc_sign;
   wire major_step = dda_en;
   // swap chooses which axis is major
   assign X_STEP_EN_N = ~(axis_swap ? minor_step : major_step);
   assign Y_STEP_EN_N = ~(axis_swap ? major_step : minor_step);

   wire [DATA_W-1:0] next_rdata =
        rd_strb[R_SHORT] ? {8'h00, short_cnt} :
        rd_strb[R_LONG]  ? {4'h0, long_cnt}   :
        rd_strb[R_ACCUM] ? accum               : DATA_ZERO;
   assign RDATA_OE = rd_strb[R_SHORT] | rd_strb[R_LONG] | rd_strb[R_ACCUM];

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         RDATA <= DATA_ZERO;
      end else if (CLK_EN) begin
         RDATA <= next_rdata;
      end
   end

   // assertions
   property p_pulse_one;
      @(posedge CLK) disable iff (SYS_RST)
      CLK_EN && sync_wr ##1 CLK_EN |-> !sync_wr;
   endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("write pulse longer than one clock");

   property p_ack_after_pulse;
      @(posedge CLK) disable iff (SYS_RST)
      CLK_EN && sync_wr && !BUS.io_write_ctl_n |=> !SYSTEM_WRITE_ACK_N || BUS.io_write_ctl_n;
   endproperty
   a_ack_after_pulse: assert property (p_ack_after_pulse) else $error("no ack after pulse");

   property p_ack_release;
      @(posedge CLK) disable iff (SYS_RST)
      BUS.io_write_ctl_n |-> SYSTEM_WRITE_ACK_N;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("ack while write released");

   property p_idle_after_release;
      @(posedge CLK) disable iff (SYS_RST)
      CLK_EN && ws_state == VGIO_WS_ACK && BUS.io_write_ctl_n |=> ws_state == VGIO_WS_IDLE;
   endproperty
   a_idle_after_release: assert property (p_idle_after_release) else $error("sync not idle");

   property p_hold_blocks;
      @(posedge CLK) disable iff (SYS_RST)
      CLK_EN && ws_state == VGIO_WS_IDLE && HOLD_REQ |=> ws_state == VGIO_WS_IDLE;
   endproperty
   a_hold_blocks: assert property (p_hold_blocks) else $error("write sync started under hold");

   property p_short_hold_zero;
      @(posedge CLK) disable iff (SYS_RST)
      CLK_EN && short_zero && !wr_short && !short_pop |=> short_zero;
   endproperty
   a_short_hold_zero: assert property (p_short_hold_zero) else $error("short counter wrapped");

   property p_short_reload;
      @(posedge CLK) disable iff (SYS_RST)
      CLK_EN && short_pop && !wr_short && !clr |=> short_cnt == $past(short_latch)
                                           && short_latch == $past(short_latch);
   endproperty
   a_short_reload: assert property (p_short_reload) else $error("reload mismatch");

   property p_long_load_flag;
      @(posedge CLK) disable iff (SYS_RST)
      CLK_EN && wr_long |=> LONG_LOOP_ZERO_DELAYED_N;
   endproperty
   a_long_load_flag: assert property (p_long_load_flag) else $error("delayed zero set on load");

   property p_long_hold_flag;
      @(posedge CLK) disable iff (SYS_RST)
      CLK_EN && !wr_long && !long_en && !clr |=> $stable(long_zero_dly);
   endproperty
   a_long_hold_flag: assert property (p_long_hold_flag) else $error("delayed zero moved while idle");

   property p_accum_clear;
      @(posedge CLK) disable iff (SYS_RST)
      CLK_EN && wr_accum && !clr |=> accum == ACC_RST && inc_b == $past(BUS.wdata);
   endproperty
   a_accum_clear: assert property (p_accum_clear) else $error("accum port write wrong");

   property p_accum_step;
      @(posedge CLK) disable iff (SYS_RST)
      CLK_EN && dda_en && !wr_accum && !wr_inc_a && !wr_inc_b && !clr
      |=> accum == 16'($past(accum) + ($past(accum[ACC_W-1]) ? $past(inc_a) : $past(inc_b)));
   endproperty
   a_accum_step: assert property (p_accum_step) else $error("accumulator step wrong");

   property p_soft_clear;
      @(posedge CLK) disable iff (SYS_RST)
      CLK_EN && wr_swrst |=> short_cnt == SHORT_RST && long_cnt == LONG_RST && accum == ACC_RST;
   endproperty
   a_soft_clear: assert property (p_soft_clear) else $error("software reset left state");

   c_write_cycle: cover property (@(posedge CLK) disable iff (SYS_RST)
                                  sync_wr ##1 !SYSTEM_WRITE_ACK_N);
   c_short_zero:  cover property (@(posedge CLK) disable iff (SYS_RST)
                                  !short_zero ##1 short_zero);
   c_axis_load:   cover property (@(posedge CLK) disable iff (SYS_RST) wr_axis);

endmodule // vgio_top

`default_nettype wire
